// ===== hw/pcp_pkg.sv
/*
 package for the position command pulse block: register map, reset
 values, field layouts, timing constants and carrier structs.
 assumes a 125 MHz system clock and a 32-bit classic wishbone bus.
*/
package pcp_pkg;
   localparam int unsigned CLK_HZ = 125000000;
   localparam int unsigned GEAR_DELAY_MS = 100;
   localparam int unsigned GEAR_DELAY_CYC = GEAR_DELAY_MS * (CLK_HZ / 1000);
   localparam int unsigned MS_CYC = CLK_HZ / 1000;
   // register byte offsets
   localparam logic [7:0] REG_GEAR_SEL = 8'h00;
   localparam logic [7:0] REG_FILT_TIME = 8'h04;
   localparam logic [7:0] REG_GATING = 8'h08;
   localparam logic [7:0] REG_GEAR_NUM1 = 8'h0c;
   localparam logic [7:0] REG_GEAR_DEN1 = 8'h10;
   localparam logic [7:0] REG_GEAR_NUM2 = 8'h14;
   localparam logic [7:0] REG_GEAR_DEN2 = 8'h18;
   localparam logic [7:0] REG_DIV_NUM = 8'h1c;
   localparam logic [7:0] REG_DIV_DEN = 8'h20;
   localparam logic [7:0] REG_Z_WIDTH = 8'h24;
   localparam logic [7:0] REG_OUT_CFG = 8'h28;
   localparam logic [7:0] REG_DEVIATION = 8'h2c;
   localparam logic [7:0] REG_STATUS = 8'h30;
   // reset values and write limits
   localparam logic [15:0] RST_GEAR_SEL = 16'h0001;
   localparam logic [15:0] RST_FILT_TIME = 16'h0001;
   localparam logic [15:0] RST_GATING = 16'h0000;
   localparam logic [15:0] RST_GEAR_NUM = 16'h0000;
   localparam logic [15:0] RST_GEAR_DEN = 16'h2710;
   localparam logic [15:0] RST_DIV_NUM = 16'h2710;
   localparam logic [15:0] RST_DIV_DEN = 16'h2710;
   localparam logic [15:0] RST_Z_WIDTH = 16'h01f4;
   localparam logic [15:0] RST_OUT_CFG = 16'h0000;
   localparam logic [15:0] Z_WIDTH_MIN = 16'h0032;
   localparam logic [15:0] Z_WIDTH_MAX = 16'h7530;
   localparam logic [15:0] FILT_MAX = 16'h2710;
   // field positions and gear select codes
   localparam int unsigned GATE_INHIBIT_BIT = 0;
   localparam int unsigned GATE_CLEAR_BIT = 4;
   localparam int unsigned OUT_PHASE_BIT = 0;
   localparam int unsigned OUT_SRC_BIT = 4;
   localparam logic [1:0] SEL_FIRST = 2'h0;
   localparam logic [1:0] SEL_SECOND = 2'h1;
   localparam logic [1:0] SEL_SWITCH = 2'h2;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [7:0] adr;
      logic [31:0] dat;
   } pcp_wb_req_t;

   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } pcp_wb_rsp_t;

   typedef struct packed {
      logic step;
      logic dir;
   } pcp_pulse_t;
endpackage

// ===== hw/pcp_top.sv
/*
 position command pulse processing: gear scaling with switchover,
 command smoothing filter, pulse inhibit, deviation register with
 clear, divided A/B quadrature output and stretched Z home pulse.
 assumes a wishbone classic master on sys_clk; all terminal and
 encoder inputs are asynchronous pins.
*/
// Overview of operation
// - gear select 0,1,2; resets to 1
// - switch mode: terminal picks exactly one ratio
// - new ratio takes effect 100 ms later
// - command equals pulses times B over A
// - filter time constant 1 to 10000 ms
// - filter preserves total pulse count
// - inhibit input blocks pulse counting
// - inhibit honoured only when gating digit A set
// - deviation is command minus feedback
// - clear input zeroes deviation register
// - clear honoured only when gating digit B set
// - encoder stream divided into quadrature A/B
// - A/B pulses per rev set by numerator
// - A/B width follows motor speed
// - source and phase settings configurable
// - Z pulse undivided on diff and open collector
// - Z pulse stretched by width setting
// - phase 0: A leads forward; 1 reverses
// - zero numerator: denominator is pulses per rev
// - Z width accepted only 50 to 30000
`timescale 1ns/1ps
module pcp_top
   import pcp_pkg::*;
#(
   parameter int unsigned GEAR_DLY = GEAR_DELAY_CYC,
   parameter int unsigned MS_TICK = MS_CYC,
   parameter int unsigned ENC_PPR = 32'd131072
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire pcp_wb_req_t wb_req,
   output pcp_wb_rsp_t wb_rsp,
   input wire pcp_pulse_t cmd_pulse,
   input wire logic gear_switch_input,
   input wire logic pulse_count_block_input,
   input wire logic deviation_clear_input,
   input wire pcp_pulse_t enc_pulse,
   input wire logic enc_z,
   input wire pcp_pulse_t load_pulse,
   output logic phase_a_divided_out,
   output logic phase_b_divided_out,
   output logic home_pulse_diff_out,
   output logic home_pulse_open_collector,
   output logic [31:0] filtered_cmd
);
   default clocking chk_cb @(posedge sys_clk); endclocking
   default disable iff (srst);
   // two-flop synchronisers for all pin inputs except the unused load_pulse.dir
   localparam int NS = 9;
   logic [NS-1:0] pin_raw, s1_q, s2_q, s3_q;
   assign pin_raw = {cmd_pulse.step, cmd_pulse.dir, gear_switch_input,
                     pulse_count_block_input, deviation_clear_input,
                     enc_pulse.step, enc_pulse.dir, enc_z, load_pulse.step};
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else begin
         s1_q <= pin_raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end
   logic c_step, c_dir, g_sw, inh_in, clr_in, e_step, e_dir, e_z, ls_step;
   assign {c_step, c_dir, g_sw, inh_in, clr_in, e_step, e_dir, e_z,
           ls_step} = s2_q;
   function automatic logic rise(input int i);
      return s2_q[i] && !s3_q[i];
   endfunction
   logic cmd_edge, enc_edge, z_edge;
   assign cmd_edge = rise(8);
   assign enc_edge = rise(3);
   assign z_edge = rise(1);

   // register file
   logic [15:0] gear_ratio_select_q, position_filter_time_q;
   logic [15:0] command_input_gating_q, div_num_q, div_den_q;
   logic [15:0] z_width_q, out_cfg_q;
   logic [15:0] gnum_q [2];
   logic [15:0] gden_q [2];
   logic [31:0] dev_q, rd_d;
   logic ack_q, wr_go;
   logic [31:0] wdat;
   assign wr_go = wb_req.cyc && wb_req.stb && wb_req.we && !ack_q;
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         wdat[i*8 +: 8] = wb_req.sel[i] ? wb_req.dat[i*8 +: 8] : 8'h00;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= wb_req.cyc && wb_req.stb && !ack_q;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         gear_ratio_select_q <= RST_GEAR_SEL;
         position_filter_time_q <= RST_FILT_TIME;
         command_input_gating_q <= RST_GATING;
         gnum_q[0] <= RST_GEAR_NUM;
         gnum_q[1] <= RST_GEAR_NUM;
         gden_q[0] <= RST_GEAR_DEN;
         gden_q[1] <= RST_GEAR_DEN;
         div_num_q <= RST_DIV_NUM;
         div_den_q <= RST_DIV_DEN;
         z_width_q <= RST_Z_WIDTH;
         out_cfg_q <= RST_OUT_CFG;
      end else if (wr_go) begin
         case (wb_req.adr)
            REG_GEAR_SEL: if (wdat[15:0] <= 16'h0002)
               gear_ratio_select_q <= wdat[15:0];
            REG_FILT_TIME: if (wdat[15:0] != 16'h0000 &&
                               wdat[15:0] <= FILT_MAX)
               position_filter_time_q <= wdat[15:0];
            REG_GATING: command_input_gating_q <= wdat[15:0];
            REG_GEAR_NUM1: gnum_q[0] <= wdat[15:0];
            REG_GEAR_DEN1: if (wdat[15:0] != 16'h0000) gden_q[0] <= wdat[15:0];
            REG_GEAR_NUM2: gnum_q[1] <= wdat[15:0];
            REG_GEAR_DEN2: if (wdat[15:0] != 16'h0000) gden_q[1] <= wdat[15:0];
            REG_DIV_NUM: if (wdat[15:0] != 16'h0000) div_num_q <= wdat[15:0];
            REG_DIV_DEN: if (wdat[15:0] != 16'h0000) div_den_q <= wdat[15:0];
            REG_Z_WIDTH: if (wdat[15:0] >= Z_WIDTH_MIN &&
                             wdat[15:0] <= Z_WIDTH_MAX)
               z_width_q <= wdat[15:0];
            REG_OUT_CFG: out_cfg_q <= wdat[15:0];
            default: ;
         endcase
      end
   end

   // gear selection with delayed switchover
   logic act_gear_q, g_sw_seen_q;
   logic [31:0] gdly_q;
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         act_gear_q <= 1'b1;
         g_sw_seen_q <= 1'b0;
         gdly_q <= '0;
      end else begin
         case (gear_ratio_select_q[1:0])
            SEL_FIRST: act_gear_q <= 1'b0;
            SEL_SECOND: act_gear_q <= 1'b1;
            SEL_SWITCH: begin
               // one ratio at a time, terminal change lands late
               if (g_sw != g_sw_seen_q) begin
                  g_sw_seen_q <= g_sw;
                  gdly_q <= 32'd1;
               end else if (gdly_q != 32'd0) begin
                  if (gdly_q >= GEAR_DLY) begin
                     act_gear_q <= g_sw_seen_q;
                     gdly_q <= '0;
                  end else begin
                     gdly_q <= gdly_q + 32'd1;
                  end
               end else if (act_gear_q != g_sw_seen_q) begin
                  gdly_q <= 32'd1;
               end
            end
            default: act_gear_q <= 1'b1;
         endcase
      end
   end

   // gear scaling: accumulate B per pulse, emit per A, keep remainder
   logic [15:0] num_a, den_a;
   logic [16:0] num_eff;
   logic [31:0] acc_q;
   logic signed [31:0] gear_cnt_q;
   logic cmd_take;
   assign num_a = gnum_q[act_gear_q];
   assign den_a = gden_q[act_gear_q];
   // zero numerator: den pulses per rev, i.e. ratio enc_ppr / den
   assign num_eff = (num_a == 16'h0000) ? 17'h10000 : {1'b0, num_a};
   assign cmd_take = cmd_edge && !(inh_in &&
      command_input_gating_q[GATE_INHIBIT_BIT]);
   logic [31:0] step_num, step_den;
   assign step_num = (num_a == 16'h0000) ? ENC_PPR : {15'h0000, num_eff};
   assign step_den = {16'h0000, den_a};
   logic [31:0] add_d, emit_n;
   always_comb begin
      add_d = acc_q + (cmd_take ? step_num : 32'h0);
      emit_n = add_d / step_den;
   end
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         acc_q <= '0;
         gear_cnt_q <= '0;
      end else begin
         acc_q <= add_d - emit_n * step_den;
         if (c_dir)
            gear_cnt_q <= gear_cnt_q - $signed(emit_n);
         else
            gear_cnt_q <= gear_cnt_q + $signed(emit_n);
      end
   end

   // first-order filter, stepped each ms; residual settles exactly
   logic [31:0] ms_q;
   logic signed [31:0] filt_q, err;
   logic signed [31:0] stepv;
   assign err = gear_cnt_q - filt_q;
   always_comb begin
      stepv = err / $signed({16'h0000, position_filter_time_q});
      if (stepv == 0 && err != 0)
         stepv = (err > 0) ? 32'sd1 : -32'sd1;
   end
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         ms_q <= '0;
         filt_q <= '0;
      end else if (ms_q >= MS_TICK - 1) begin
         ms_q <= '0;
         filt_q <= filt_q + stepv;
      end else begin
         ms_q <= ms_q + 32'd1;
      end
   end
   assign filtered_cmd = filt_q;

   // deviation register
   logic signed [31:0] fb_q, cmd_base_q;
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         fb_q <= '0;
         cmd_base_q <= '0;
         dev_q <= '0;
      end else begin
         if (enc_edge)
            fb_q <= e_dir ? fb_q - 32'sd1 : fb_q + 32'sd1;
         if (clr_in && command_input_gating_q[GATE_CLEAR_BIT]) begin
            cmd_base_q <= filt_q - fb_q;
            dev_q <= '0;
         end else begin
            dev_q <= filt_q - cmd_base_q - fb_q;
         end
      end
   end

   // divided quadrature output: accumulate num per source edge over den
   logic src_edge, src_dir;
   logic [31:0] dacc_q, dacc_n;
   logic [1:0] quad_q;
   assign src_edge = out_cfg_q[OUT_SRC_BIT] ? rise(0) : enc_edge;
   assign src_dir = out_cfg_q[OUT_SRC_BIT] ? 1'b0 : e_dir;
   assign dacc_n = dacc_q + {16'h0000, div_num_q};
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         dacc_q <= '0;
         quad_q <= '0;
      end else if (src_edge) begin
         // step rate tracks encoder rate, so width follows speed
         if (dacc_n >= {16'h0000, div_den_q}) begin
            dacc_q <= dacc_n - {16'h0000, div_den_q};
            quad_q <= src_dir ? quad_q - 2'h1 : quad_q + 2'h1;
         end else begin
            dacc_q <= dacc_n;
         end
      end
   end
   logic qa, qb;
   assign qa = quad_q[1] ^ quad_q[0];
   assign qb = quad_q[1];
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         phase_a_divided_out <= 1'b0;
         phase_b_divided_out <= 1'b0;
      end else if (out_cfg_q[OUT_PHASE_BIT]) begin
         phase_a_divided_out <= qb;
         phase_b_divided_out <= qa;
      end else begin
         phase_a_divided_out <= qa;
         phase_b_divided_out <= qb;
      end
   end

   // z pulse: undivided, stretched to at least z_width cycles
   logic [15:0] zcnt_q;
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         zcnt_q <= '0;
         home_pulse_diff_out <= 1'b0;
         home_pulse_open_collector <= 1'b0;
      end else begin
         if (z_edge)
            zcnt_q <= z_width_q;
         else if (zcnt_q != 16'h0000)
            zcnt_q <= zcnt_q - 16'h0001;
         home_pulse_diff_out <= z_edge || zcnt_q > 16'h0001;
         home_pulse_open_collector <= z_edge || zcnt_q > 16'h0001;
      end
   end

   // read mux
   always_comb begin
      rd_d = 32'h0;
      case (wb_req.adr)
         REG_GEAR_SEL: rd_d[15:0] = gear_ratio_select_q;
         REG_FILT_TIME: rd_d[15:0] = position_filter_time_q;
         REG_GATING: rd_d[15:0] = command_input_gating_q;
         REG_GEAR_NUM1: rd_d[15:0] = gnum_q[0];
         REG_GEAR_DEN1: rd_d[15:0] = gden_q[0];
         REG_GEAR_NUM2: rd_d[15:0] = gnum_q[1];
         REG_GEAR_DEN2: rd_d[15:0] = gden_q[1];
         REG_DIV_NUM: rd_d[15:0] = div_num_q;
         REG_DIV_DEN: rd_d[15:0] = div_den_q;
         REG_Z_WIDTH: rd_d[15:0] = z_width_q;
         REG_OUT_CFG: rd_d[15:0] = out_cfg_q;
         REG_DEVIATION: rd_d = dev_q;
         REG_STATUS: rd_d[2:0] = {inh_in, g_sw, act_gear_q};
         default: rd_d = 32'h0;
      endcase
   end
   logic [31:0] rdat_q;
   always_ff @(posedge sys_clk) begin
      if (srst)
         rdat_q <= '0;
      else
         rdat_q <= rd_d;
   end
   assign wb_rsp.ack = ack_q;
   assign wb_rsp.dat = rdat_q;
   // checks
   sequence sel_first_s;
      gear_ratio_select_q == 16'h0000 ##1 gear_ratio_select_q == 16'h0000;
   endsequence
   a_gear_reset_one: assert property ($fell(srst) |->
      gear_ratio_select_q == RST_GEAR_SEL)
      else $error("gear select reset value wrong");
   a_gear_fixed_sel: assert property (sel_first_s |-> !act_gear_q)
      else $error("first ratio not applied");
   a_gear_no_early: assert property (gdly_q != 0 &&
      gear_ratio_select_q[1:0] == SEL_SWITCH && gdly_q < GEAR_DLY |=>
      $stable(act_gear_q)) else $error("ratio switched early");
   a_inhibit_block: assert property (inh_in &&
      command_input_gating_q[GATE_INHIBIT_BIT] && acc_q < step_den |->
      emit_n == 32'h0) else $error("inhibited pulse counted");
   a_clear_zero: assert property (clr_in &&
      command_input_gating_q[GATE_CLEAR_BIT] |=> dev_q == 32'h0)
      else $error("deviation not cleared");
   a_rem_bound: assert property (acc_q < step_den ||
      $changed(act_gear_q) || $past(wr_go))
      else $error("gear remainder out of range");
   a_z_stretch: assert property (z_edge |=>
      home_pulse_diff_out [*8])
      else $error("z pulse not stretched");
   a_z_range: assert property (z_width_q >= Z_WIDTH_MIN &&
      z_width_q <= Z_WIDTH_MAX)
      else $error("z width out of range");
   a_filt_min: assert property (position_filter_time_q != 0 &&
      position_filter_time_q <= FILT_MAX)
      else $error("filter constant out of range");
   a_quad_gray: assert property ($past(out_cfg_q) ==
      $past(out_cfg_q, 2) |-> !($changed(phase_a_divided_out) &&
      $changed(phase_b_divided_out)))
      else $error("both quadrature phases moved");
endmodule // pcp_top

// ===== verif/pcp_host_model.sv
/*
 host motion controller model: sends step/dir command pulses to the
 position command pulse block at a chosen step width.
 assumes the block samples its pins on sys_clk through a synchroniser.
*/
`timescale 1ns/1ps
module pcp_host_model
   import pcp_pkg::*;
(
   input wire logic sys_clk,
   output pcp_pulse_t cmd_pulse
);
   initial cmd_pulse = '0;

   // dir settles one cycle before the step edge and holds past it;
   // w = 1 is the fastest step the synchroniser can still resolve
   task automatic send(input int n, input logic dir, input int w);
      repeat (n) begin
         @(posedge sys_clk);
         cmd_pulse <= '{step: 1'b0, dir: dir};
         @(posedge sys_clk);
         cmd_pulse.step <= 1'b1;
         repeat (w) @(posedge sys_clk);
         cmd_pulse.step <= 1'b0;
         repeat (w) @(posedge sys_clk);
      end
   endtask
endmodule // pcp_host_model

// ===== verif/test_pcp_top.sv
/*
 self-checking bench for pcp_top: wishbone register tasks, command
 pulses from the host model, encoder pulses from the bench.
 assumes short gear delay and ms tick parameters and ENC_PPR of 1000.
*/
`timescale 1ns/1ps
module test_pcp_top
   import pcp_pkg::*;
;
   logic sys_clk;
   logic srst;
   pcp_wb_req_t wb_req;
   pcp_wb_rsp_t wb_rsp;
   pcp_pulse_t cmd_pulse;
   pcp_pulse_t enc_pulse;
   logic gear_sw, blk, clr, enc_z, pa, pb, zd, zo;
   logic [31:0] fcmd, q, base;
   logic [1:0] lead;
   pcp_pulse_t ld;
   int n_mismatch, tests_run;

   pcp_host_model host (.sys_clk(sys_clk), .cmd_pulse(cmd_pulse));

   pcp_top #(.GEAR_DLY(20), .MS_TICK(4), .ENC_PPR(1000)) DUT (
      .sys_clk(sys_clk), .srst(srst), .wb_req(wb_req), .wb_rsp(wb_rsp),
      .cmd_pulse(cmd_pulse), .gear_switch_input(gear_sw),
      .pulse_count_block_input(blk), .deviation_clear_input(clr),
      .enc_pulse(enc_pulse), .enc_z(enc_z), .load_pulse(ld),
      .phase_a_divided_out(pa), .phase_b_divided_out(pb),
      .home_pulse_diff_out(zd), .home_pulse_open_collector(zo),
      .filtered_cmd(fcmd));

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   task automatic check(input logic [31:0] got, exp, input string m);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // one classic cycle; read data taken at the ack edge only
   task automatic wb(input logic we, input logic [7:0] a,
                     input logic [31:0] d);
      int t;
      t = 0;
      @(posedge sys_clk);
      wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: a, dat: d};
      do begin
         @(posedge sys_clk);
         t++;
      end while (wb_rsp.ack !== 1'b1 && t < 50);
      if (t >= 50) check(1'b0, 1'b1, "no ack");
      q = wb_rsp.dat;
      wb_req <= '0;
      @(posedge sys_clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wb(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      check(q, e, "register read");
   endtask

   // filter must have delivered every pulse before the count is judged
   task automatic delta(input logic [31:0] e);
      repeat (300) @(posedge sys_clk);
      check(fcmd - base, e, "command delta");
      base = fcmd;
   endtask

   task automatic enc(input int n, input logic dir);
      repeat (n) begin
         enc_pulse <= '{step: 1'b0, dir: dir};
         @(posedge sys_clk);
         enc_pulse.step <= 1'b1;
         repeat (4) @(posedge sys_clk);
         enc_pulse.step <= 1'b0;
         repeat (3) @(posedge sys_clk);
      end
   endtask

   initial begin
      repeat (20000) @(posedge sys_clk);
      n_mismatch++;
      $display("mismatch at %0t: watchdog expired", $time);
      final_report();
   end

   initial begin
      logic ph[3] = '{1'b0, 1'b1, 1'b0};
      logic dr[3] = '{1'b0, 1'b0, 1'b1};
      logic [1:0] ex[3] = '{2'b10, 2'b01, 2'b01};
      int k, zc, oc;
      srst = 1'b1;
      wb_req = '0;
      enc_pulse = '0;
      ld = '0;
      {gear_sw, blk, clr, enc_z} = 4'h0;
      n_mismatch = 0;
      tests_run = 0;
      repeat (2) @(posedge sys_clk);
      srst <= 1'b0;
      rd(REG_GEAR_SEL, 32'h1);
      rd(REG_FILT_TIME, 32'h1);
      wr(REG_GEAR_SEL, 32'h3);
      rd(REG_GEAR_SEL, 32'h1);
      wr(REG_FILT_TIME, 32'h2711);
      rd(REG_FILT_TIME, 32'h1);
      wr(REG_FILT_TIME, 32'h3);
      rd(REG_FILT_TIME, 32'h3);
      rd(8'hfc, 32'h0);
      $display("test registers done");
      wr(REG_GEAR_NUM1, 32'h2);
      wr(REG_GEAR_DEN1, 32'h1);
      wr(REG_GEAR_SEL, 32'h0);
      base = fcmd;
      host.send(5, 1'b0, 4);
      delta(32'ha);
      host.send(2, 1'b1, 10);
      delta(32'hfffffffc);
      wr(REG_GEAR_NUM1, 32'h1);
      wr(REG_GEAR_DEN1, 32'h2);
      host.send(3, 1'b0, 2);
      host.send(1, 1'b0, 4);
      delta(32'h2);
      wr(REG_GEAR_NUM1, 32'h0);
      wr(REG_GEAR_DEN1, 32'h1f4);
      host.send(1, 1'b0, 4);
      delta(32'h2);
      $display("test gear ratio done");
      wr(REG_GEAR_NUM1, 32'h1);
      wr(REG_GEAR_DEN1, 32'h1);
      blk <= 1'b1;
      host.send(2, 1'b0, 4);
      delta(32'h2);
      wr(REG_GATING, 32'h1);
      host.send(2, 1'b0, 4);
      delta(32'h0);
      blk <= 1'b0;
      host.send(1, 1'b0, 4);
      delta(32'h1);
      $display("test inhibit done");
      wr(REG_GEAR_NUM2, 32'h3);
      wr(REG_GEAR_DEN2, 32'h1);
      wr(REG_GEAR_SEL, 32'h2);
      delta(32'h0);
      gear_sw <= 1'b1;
      repeat (2) @(posedge sys_clk);
      host.send(1, 1'b0, 2);
      delta(32'h1);
      host.send(1, 1'b0, 4);
      delta(32'h3);
      gear_sw <= 1'b0;
      $display("test switchover done");
      clr <= 1'b1;
      repeat (10) @(posedge sys_clk);
      clr <= 1'b0;
      rd(REG_DEVIATION, 32'h11);
      wr(REG_GATING, 32'h11);
      clr <= 1'b1;
      repeat (10) @(posedge sys_clk);
      clr <= 1'b0;
      rd(REG_DEVIATION, 32'h0);
      host.send(2, 1'b0, 4);
      enc(1, 1'b0);
      delta(32'h2);
      rd(REG_DEVIATION, 32'h1);
      $display("test deviation done");
      wr(REG_Z_WIDTH, 32'h3c);
      wr(REG_Z_WIDTH, 32'h31);
      rd(REG_Z_WIDTH, 32'h3c);
      enc_z <= 1'b1;
      k = 0;
      while (zd !== 1'b1 && k < 20) begin
         @(posedge sys_clk);
         k++;
      end
      enc_z <= 1'b0;
      zc = 0;
      oc = 0;
      while (zd === 1'b1 && zc < 200) begin
         if (zo === 1'b1) oc++;
         zc++;
         @(posedge sys_clk);
      end
      check(zc, 32'h3c, "z width diff");
      check(oc, 32'h3c, "z width oc");
      $display("test home pulse done");
      for (int i = 0; i < 3; i++) begin
         srst <= 1'b1;
         repeat (2) @(posedge sys_clk);
         srst <= 1'b0;
         wr(REG_OUT_CFG, {31'h0, ph[i]});
         fork
            enc(8, dr[i]);
            begin
               k = 0;
               while (pa === 1'b0 && pb === 1'b0 && k < 300) begin
                  @(posedge sys_clk);
                  k++;
               end
               lead = {pa, pb};
            end
         join
         check({30'h0, lead}, {30'h0, ex[i]}, "lead");
      end
      // half-rate divider on the load source: four pulses, two steps
      wr(REG_OUT_CFG, 32'h10);
      wr(REG_DIV_DEN, 32'h4e20);
      repeat (4) begin
         ld.step <= 1'b1;
         repeat (4) @(posedge sys_clk);
         ld.step <= 1'b0;
         repeat (4) @(posedge sys_clk);
      end
      repeat (8) @(posedge sys_clk);
      check({30'h0, pa, pb}, 32'h3, "load source");
      $display("test divided output done");
      final_report();
   end
endmodule // test_pcp_top
